// [include/rpcb_pkg.sv]
`default_nettype none
package rpcb_pkg;
   // ------------------------------------------------------------
   // register map
   // ------------------------------------------------------------
   localparam logic [7:0] OFS_PRIO_9_10 = 8'h1c;
   localparam logic [7:0] OFS_PRIO_11_12 = 8'h1d;
   localparam logic [7:0] OFS_SRC_SEL = 8'h4b;
   // printed offsets are not all multiples of four: byte address = 4 * index
   localparam int ADDR_W = 10;
   localparam int PATH_SEL_BIT = 4;
   localparam int HI_NIB_LSB = 4;
   localparam int LO_NIB_LSB = 0;
   localparam logic [7:0] RST_9_10_PRI = 8'hba;
   localparam logic [7:0] RST_9_10_SEC = 8'hba;
   localparam logic [7:0] RST_11_12_PRI = 8'hdc;
   localparam logic [7:0] RST_11_12_SEC = 8'h00;
   localparam logic [7:0] RST_SRC_SEL = 8'h00;
   localparam logic [1:0] RESP_OKAY = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;

   // one copy of the priority settings of one clock path
   typedef struct packed {
      logic [3:0] in12;
      logic [3:0] in11;
      logic [3:0] in10;
      logic [3:0] in9;
   } rpcb_prio_t;
endpackage
`default_nettype wire

// [rtl/rpcb_bank.sv]
`default_nettype none
// Functional notes
// R1 - separate 4-bit priorities; input 10 high, 9 low
// R2 - input 12 priority in upper nibble
// R3 - smaller nonzero value means higher priority
// R4 - zero excludes input; 1 to 15 candidate
// R5 - path select zero addresses primary copy
// R6 - path select one addresses secondary copy
// R7 - inputs 9/10 register RW, both reset 0xba
// R8 - inputs 11/12 reset primary 0xdc, secondary 0x00
// R9 - reads return copy chosen by path select
module rpcb_bank (
   input wire logic clk,
   input wire logic srst,
   input wire logic [rpcb_pkg::ADDR_W-1:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic [rpcb_pkg::ADDR_W-1:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready,
   output rpcb_pkg::rpcb_prio_t primary_clock_path_prio,
   output rpcb_pkg::rpcb_prio_t secondary_clock_path_prio,
   output logic [3:0] primary_best_input,
   output logic [3:0] secondary_best_input
);
   // ------------------------------------------------------------
   // write channel capture
   // ------------------------------------------------------------
   logic aw_full_q, aw_full_d, w_full_q, w_full_d;
   logic [rpcb_pkg::ADDR_W-1:0] awaddr_q, awaddr_d;
   logic [7:0] wdata_q, wdata_d;
   logic wstrb0_q, wstrb0_d;
   logic bvalid_q, bvalid_d;
   logic [1:0] bresp_q, bresp_d;
   logic [7:0] pr910_q, pr910_d, se910_q, se910_d;
   logic [7:0] pr1112_q, pr1112_d, se1112_q, se1112_d;
   logic [7:0] srcsel_q, srcsel_d;
   wire wr_go = aw_full_q && w_full_q && !bvalid_q;
   wire [rpcb_pkg::ADDR_W-1:0] wr_idx = {2'h0, awaddr_q[rpcb_pkg::ADDR_W-1:2]};
   wire wr_aligned = awaddr_q[1:0] == 2'h0;
   wire wr_910 = wr_aligned && wr_idx == {2'h0, rpcb_pkg::OFS_PRIO_9_10};
   wire wr_1112 = wr_aligned && wr_idx == {2'h0, rpcb_pkg::OFS_PRIO_11_12};
   wire wr_src = wr_aligned && wr_idx == {2'h0, rpcb_pkg::OFS_SRC_SEL};
   wire wr_hit = wr_910 || wr_1112 || wr_src;
   wire wr_en = wr_go && wstrb0_q;
   wire path_sec = srcsel_q[rpcb_pkg::PATH_SEL_BIT];

   // accept each of aw and w independently, one write in flight
   assign s_axi_awready = !aw_full_q;
   assign s_axi_wready = !w_full_q;
   assign aw_full_d = wr_go ? 1'b0 : (aw_full_q || s_axi_awvalid);
   assign w_full_d = wr_go ? 1'b0 : (w_full_q || s_axi_wvalid);
   assign awaddr_d = (!aw_full_q && s_axi_awvalid) ? s_axi_awaddr : awaddr_q;
   assign wdata_d = (!w_full_q && s_axi_wvalid) ? s_axi_wdata[7:0] : wdata_q;
   assign wstrb0_d = (!w_full_q && s_axi_wvalid) ? s_axi_wstrb[0] : wstrb0_q;
   assign bvalid_d = wr_go ? 1'b1 : (bvalid_q && !s_axi_bready);
   assign bresp_d = wr_go ? (wr_hit ? rpcb_pkg::RESP_OKAY
                                    : rpcb_pkg::RESP_SLVERR) : bresp_q;
   assign s_axi_bvalid = bvalid_q;
   assign s_axi_bresp = bresp_q;

   // ------------------------------------------------------------
   // register copies, steered by the path select bit
   // ------------------------------------------------------------
   // the write lands in one copy only; the other path keeps its setting
   assign pr910_d = (wr_en && wr_910 && !path_sec) ? wdata_q : pr910_q; // R5
   assign se910_d = (wr_en && wr_910 && path_sec) ? wdata_q : se910_q; // R6
   assign pr1112_d = (wr_en && wr_1112 && !path_sec) ? wdata_q
                                                      : pr1112_q; // R5
   assign se1112_d = (wr_en && wr_1112 && path_sec) ? wdata_q : se1112_q; // R6
   assign srcsel_d = (wr_en && wr_src) ? wdata_q : srcsel_q;

   always_ff @(posedge clk) begin
      if (srst) begin
         aw_full_q <= 1'b0;
         w_full_q <= 1'b0;
         awaddr_q <= '0;
         wdata_q <= 8'h00;
         wstrb0_q <= 1'b0;
         bvalid_q <= 1'b0;
         bresp_q <= rpcb_pkg::RESP_OKAY;
         pr910_q <= rpcb_pkg::RST_9_10_PRI; // R7
         se910_q <= rpcb_pkg::RST_9_10_SEC; // R7
         pr1112_q <= rpcb_pkg::RST_11_12_PRI; // R8
         se1112_q <= rpcb_pkg::RST_11_12_SEC; // R8
         srcsel_q <= rpcb_pkg::RST_SRC_SEL;
      end else begin
         aw_full_q <= aw_full_d;
         w_full_q <= w_full_d;
         awaddr_q <= awaddr_d;
         wdata_q <= wdata_d;
         wstrb0_q <= wstrb0_d;
         bvalid_q <= bvalid_d;
         bresp_q <= bresp_d;
         pr910_q <= pr910_d;
         se910_q <= se910_d;
         pr1112_q <= pr1112_d;
         se1112_q <= se1112_d;
         srcsel_q <= srcsel_d;
      end
   end

   // ------------------------------------------------------------
   // read channel
   // ------------------------------------------------------------
   logic rvalid_q, rvalid_d;
   logic [31:0] rdata_q, rdata_d;
   logic [1:0] rresp_q, rresp_d;
   wire rd_go = s_axi_arvalid && !rvalid_q;
   wire [rpcb_pkg::ADDR_W-1:0] rd_idx =
      {2'h0, s_axi_araddr[rpcb_pkg::ADDR_W-1:2]};
   wire rd_aligned = s_axi_araddr[1:0] == 2'h0;
   wire rd_910 = rd_aligned && rd_idx == {2'h0, rpcb_pkg::OFS_PRIO_9_10};
   wire rd_1112 = rd_aligned && rd_idx == {2'h0, rpcb_pkg::OFS_PRIO_11_12};
   wire rd_src = rd_aligned && rd_idx == {2'h0, rpcb_pkg::OFS_SRC_SEL};
   // read shows only the copy the path select points at
   wire [7:0] rd_910_v = path_sec ? se910_q : pr910_q; // R9
   wire [7:0] rd_1112_v = path_sec ? se1112_q : pr1112_q; // R9
   wire [7:0] rd_byte = rd_910 ? rd_910_v :
                        rd_1112 ? rd_1112_v :
                        rd_src ? srcsel_q : 8'h00;

   assign s_axi_arready = !rvalid_q;
   assign rdata_d = rd_go ? {24'h000000, rd_byte} : rdata_q;
   assign rresp_d = rd_go ? ((rd_910 || rd_1112 || rd_src)
                     ? rpcb_pkg::RESP_OKAY : rpcb_pkg::RESP_SLVERR) : rresp_q;
   assign rvalid_d = rd_go ? 1'b1 : (rvalid_q && !s_axi_rready);
   assign s_axi_rvalid = rvalid_q;
   assign s_axi_rdata = rdata_q;
   assign s_axi_rresp = rresp_q;

   // read answer held until rready
   always_ff @(posedge clk) begin
      if (srst) begin
         rvalid_q <= 1'b0;
         rdata_q <= 32'h00000000;
         rresp_q <= rpcb_pkg::RESP_OKAY;
      end else begin
         rvalid_q <= rvalid_d;
         rdata_q <= rdata_d;
         rresp_q <= rresp_d;
      end
   end

   // ------------------------------------------------------------
   // priority fields to the selection logic
   // ------------------------------------------------------------
   assign primary_clock_path_prio.in10 = pr910_q[7:4]; // R1
   assign primary_clock_path_prio.in9 = pr910_q[3:0]; // R1
   assign primary_clock_path_prio.in12 = pr1112_q[7:4]; // R2
   assign primary_clock_path_prio.in11 = pr1112_q[3:0];
   assign secondary_clock_path_prio.in10 = se910_q[7:4]; // R1
   assign secondary_clock_path_prio.in9 = se910_q[3:0]; // R1
   assign secondary_clock_path_prio.in12 = se1112_q[7:4]; // R2
   assign secondary_clock_path_prio.in11 = se1112_q[3:0];

   // best candidate among 9..12 per path; 0 means none, ties go low input
   function automatic logic [3:0] best_of(input rpcb_pkg::rpcb_prio_t p);
      logic [3:0] vals [4];
      logic [3:0] best_v;
      logic [3:0] best_i;
      vals[0] = p.in9;
      vals[1] = p.in10;
      vals[2] = p.in11;
      vals[3] = p.in12;
      best_v = 4'hf;
      best_i = 4'h0;
      for (int k = 0; k < 4; k++) begin
         // zero excludes; strictly smaller wins
         if (vals[k] != 4'h0 &&
             (best_i == 4'h0 || vals[k] < best_v)) begin // R3 R4
            best_v = vals[k];
            best_i = 4'(k + 9);
         end
      end
      return best_i;
   endfunction

   // registered so the data outputs come from flip-flops
   always_ff @(posedge clk) begin
      if (srst) begin
         primary_best_input <= 4'h0;
         secondary_best_input <= 4'h0;
      end else begin
         primary_best_input <= best_of(primary_clock_path_prio);
         secondary_best_input <= best_of(secondary_clock_path_prio);
      end
   end

   // ------------------------------------------------------------
   // checks
   // ------------------------------------------------------------
   sequence wr_sec_910_s;
      wr_en && wr_910 && path_sec;
   endsequence

   reset_values_a: assert property (@(posedge clk) $fell(srst) |-> // R7
      pr910_q == 8'hba && se910_q == 8'hba)
      else $error("9/10 reset value wrong");
   reset_1112_a: assert property (@(posedge clk) $fell(srst) |-> // R8
      pr1112_q == 8'hdc && se1112_q == 8'h00)
      else $error("11/12 reset value wrong");
   prim_write_a: assert property (@(posedge clk) disable iff (srst) // R5
      wr_en && wr_910 && !path_sec |=> pr910_q == $past(wdata_q)
      && $stable(se910_q))
      else $error("primary write misrouted");
   sec_write_a: assert property (@(posedge clk) disable iff (srst) // R6
      wr_sec_910_s |=> se910_q == $past(wdata_q) && $stable(pr910_q))
      else $error("secondary write misrouted");
   read_copy_a: assert property (@(posedge clk) disable iff (srst) // R9
      rd_go && rd_1112 |=> s_axi_rvalid &&
      s_axi_rdata[7:0] == ($past(path_sec) ? $past(se1112_q)
                                           : $past(pr1112_q)))
      else $error("read returned wrong copy");
   // the written byte must come out split into the right nibbles
   field_map_a: assert property (@(posedge clk) disable iff (srst) // R1
      wr_en && wr_910 && !path_sec |=>
      primary_clock_path_prio.in10 == $past(wdata_q[7:4]) &&
      primary_clock_path_prio.in9 == $past(wdata_q[3:0]))
      else $error("nibble mapping wrong");
   field_12_a: assert property (@(posedge clk) disable iff (srst) // R2
      wr_en && wr_1112 && path_sec |=>
      secondary_clock_path_prio.in12 == $past(wdata_q[7:4]))
      else $error("input 12 nibble wrong");
   zero_excl_a: assert property (@(posedge clk) disable iff (srst) // R4
      primary_best_input == 4'h9 |-> $past(pr910_q[3:0]) != 4'h0)
      else $error("disabled input chosen");
   lower_wins_a: assert property (@(posedge clk) disable iff (srst) // R3
      primary_best_input == 4'ha && $past(pr910_q[3:0]) != 4'h0 |->
      $past(pr910_q[7:4]) < $past(pr910_q[3:0]))
      else $error("larger value preferred");
endmodule
`default_nettype wire

// [tb/rpcb_bank_tb.sv]
`default_nettype none
module rpcb_bank_tb;
   timeunit 1ns;
   timeprecision 1ns;
   // ------------------------------------------------------------
   // signals and model state
   // ------------------------------------------------------------
   logic clk, srst, awvalid, awready, wvalid, wready, bvalid, bready;
   logic arvalid, arready, rvalid, rready;
   logic [9:0] awaddr, araddr;
   logic [31:0] wdata, rdata, r;
   logic [3:0] wstrb, pbest, sbest;
   logic [1:0] bresp, rresp;
   rpcb_pkg::rpcb_prio_t pprio, sprio;
   int miscompares = 0, n_checks = 0, cycles = 0, i;
   integer seed;
   logic [7:0] m_reg[2][2]; // model copies, [path][register]
   logic [7:0] m_sel;
   logic [9:0] addr_tab[4] = '{10'h070, 10'h074, 10'h12c, 10'h071};

   rpcb_bank rpcb_bank_i (.clk(clk), .srst(srst), .s_axi_awaddr(awaddr),
      .s_axi_awvalid(awvalid), .s_axi_awready(awready),
      .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid),
      .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
      .s_axi_bready(bready), .s_axi_araddr(araddr),
      .s_axi_arvalid(arvalid), .s_axi_arready(arready),
      .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
      .s_axi_rready(rready), .primary_clock_path_prio(pprio),
      .secondary_clock_path_prio(sprio), .primary_best_input(pbest),
      .secondary_best_input(sbest));

   // free-running 10 MHz clock
   initial begin
      clk = 1'b0;
      forever #50 clk = ~clk;
   end

   // hang guard: the whole run needs well under this many cycles
   always @(posedge clk) begin
      cycles <= cycles + 1;
      if (cycles == 20000) begin
         miscompares++;
         tally_and_finish();
      end
   end

   // ------------------------------------------------------------
   // helpers
   // ------------------------------------------------------------
   task automatic chk(input string what, input logic [31:0] seen, exp);
      n_checks++;
      if (seen !== exp) begin
         miscompares++;
         $display("wrong value %s expected %h seen %h", what, exp, seen);
      end
   endtask

   task automatic tally_and_finish();
      if (miscompares == 0 && n_checks > 0)
         $display("DONE - PASS");
      else
         $display("DONE - FAIL");
      $finish;
   endtask

   function automatic logic mapped(input logic [9:0] a);
      return a == 10'h070 || a == 10'h074 || a == 10'h12c;
   endfunction

   // lowest nonzero value wins, ties go to the lower input number
   function automatic logic [3:0] best(input logic [15:0] v);
      int b, bi, k;
      b = 16;
      bi = 0;
      for (k = 0; k < 4; k++) begin
         if (v[4*k+:4] != 4'h0 && v[4*k+:4] < b) begin
            b = v[4*k+:4];
            bi = 9 + k;
         end
      end
      return bi[3:0];
   endfunction

   task automatic check_ports();
      chk("primary copy", pprio, {m_reg[0][1], m_reg[0][0]});
      chk("secondary copy", sprio, {m_reg[1][1], m_reg[1][0]});
      chk("primary best", pbest, best({m_reg[0][1], m_reg[0][0]}));
      chk("secondary best", sbest, best({m_reg[1][1], m_reg[1][0]}));
   endtask

   // a leading edge keeps back-to-back tasks from driving twice at once
   task automatic wr(input logic [9:0] a, input logic [31:0] d,
                     input logic [3:0] s);
      @(posedge clk);
      awaddr <= a;
      wdata <= d;
      wstrb <= s;
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      bready <= 1'b1;
      do begin
         @(posedge clk);
         if (awready) awvalid <= 1'b0;
         if (wready) wvalid <= 1'b0;
      end while (!bvalid);
      bready <= 1'b0;
      chk("write response", bresp, mapped(a) ? 2'h0 : 2'h2);
      if (mapped(a) && s[0]) begin
         if (a == 10'h12c) m_sel = d[7:0];
         else m_reg[m_sel[4]][a[2]] = d[7:0];
      end
   endtask

   task automatic rd(input logic [9:0] a);
      @(posedge clk);
      araddr <= a;
      arvalid <= 1'b1;
      rready <= 1'b1;
      do begin
         @(posedge clk);
         if (arready) arvalid <= 1'b0;
      end while (!rvalid);
      rready <= 1'b0;
      chk("read response", rresp, mapped(a) ? 2'h0 : 2'h2);
      chk("read data", rdata, !mapped(a) ? 32'h0 : (a == 10'h12c) ?
          {24'h0, m_sel} : {24'h0, m_reg[m_sel[4]][a[2]]});
   endtask

   task automatic do_reset();
      srst <= 1'b1;
      repeat (6) @(posedge clk);
      srst <= 1'b0;
      m_reg[0][0] = 8'hba;
      m_reg[1][0] = 8'hba;
      m_reg[0][1] = 8'hdc;
      m_reg[1][1] = 8'h00;
      m_sel = 8'h00;
      repeat (2) @(posedge clk);
      check_ports();
      for (i = 0; i < 2; i++) begin
         wr(10'h12c, i << 4, 4'hf);
         rd(10'h070);
         rd(10'h074);
      end
   endtask

   // ------------------------------------------------------------
   // main sequence
   // ------------------------------------------------------------
   initial begin
      {srst, awvalid, wvalid, bready, arvalid, rready} = 6'h01 << 5;
      {awaddr, araddr, wdata, wstrb} = '0;
      seed = 32'h095b;
      do_reset();
      // all zero on the primary copy: nothing is a candidate
      wr(10'h12c, 32'h0, 4'hf);
      wr(10'h070, 32'h0, 4'hf);
      wr(10'h074, 32'h0, 4'hf);
      @(posedge clk);
      check_ports();
      // random mix: both copies, strobes off, stray addresses
      for (int n = 0; n < 80; n++) begin
         r = $random(seed);
         if (r[2])
            wr(r[3] ? r[31:22] : addr_tab[r[1:0]], $random(seed), r[7:4]);
         else
            rd(r[3] ? r[31:22] : addr_tab[r[1:0]]);
         @(posedge clk);
         check_ports();
      end
      // reset again at the end of the run after the copies were changed
      do_reset();
      tally_and_finish();
   end
endmodule
`default_nettype wire
